// ### rtl/tdg_gateway.sv
// serial port selection, modbus write guard and trending record framer
// How it works
// - pc port runs 19200 baud, 8 data bits, no parity, one stop bit
// - during firmware update the pc port bit rate becomes 38400 automatically
// - pc port and automation port are never active together
// - three operating modes; controller link bridged to at most one serial port
// - with gateway type modbus the automation port is a modbus rtu slave; the master starts every exchange
// - automation writes to safety data and lockout resets are refused
// - gateway type picks ebus, modbus or data output; data output streams records
// - data output uses the modbus character format and bit rate
// - record starts with phase byte then fuel train code byte
// - fields 3 to 7 are actuator positions in tenths plus 100
// - field 8 is drive speed in tenths of percent plus 100
// - fields 9 and 10 are oxygen and load actual values in tenths of percent
// - fields 11 and 12 are actual and set temperature or pressure words
// - field 13 is trim manipulated variable in tenths offset by 500
// - field 14 trim status byte, field 15 oxygen setpoint byte
// - field 16 recirculation temperature word, field 17 flame signal byte
// - up to 8 boilers; load source is bus setpoint or bus load
// - master gives release and demand; device returns value, state, output, errors
// - display defaults to normal view; info or both select keys return there
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module tdg_gateway
   import tdg_pkg::*;
#(
   parameter logic [15:0] PC_DIV_STD_P = 16'(PC_DIV_STD),
   parameter logic [15:0] PC_DIV_FW_P = 16'(PC_DIV_FW)
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pc service port
   input wire logic pc_rxd_i,
   output logic pc_txd_o,
   output logic pc_bit_tick_o,
   output logic pc_fw_rate_o,
   // building automation port
   input wire logic ba_rxd_i,
   output logic ba_txd_o,
   input wire tdg_bawr_t ba_wr_i,
   output logic ba_wr_grant_o,
   output logic ba_wr_reject_o,
   // controller link
   input wire logic link_txd_i,
   output logic link_rxd_o,
   input wire tdg_trend_t trend_i,
   input wire tdg_lcstat_t lcstat_i,
   output logic [2:0] boiler_addr_o,
   output logic lc_release_o,
   output logic load_controller_source_select_o,
   output logic [15:0] demand_o,
   // operating unit keys and view
   input wire logic key_info_i,
   input wire logic key_left_i,
   input wire logic key_right_i,
   input wire logic menu_enter_i,
   output logic view_normal_o,
   output logic record_busy_o
);
   // ****************************************
   // wishbone register file
   // ****************************************
   logic [31:0] ctrl_reg, mbcfg_reg, demand_reg, rd_data;
   logic [31:0] wmask;
   logic ack_reg;
   logic [7:0] reject_cnt_reg;
   wire logic req = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire logic wr = req & wb_we_i;
   wire logic hit_ctrl = wb_adr_i == ADR_CTRL;
   wire logic hit_mbcfg = wb_adr_i == ADR_MBCFG;
   wire logic hit_demand = wb_adr_i == ADR_DEMAND;
   wire logic hit_status = wb_adr_i == ADR_STATUS;
   wire logic hit_lcstat = wb_adr_i == ADR_LCSTAT;

   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_lane
         assign wmask[gb*8 +: 8] = {8{wb_sel_i[gb]}};
      end
   endgenerate

   wire logic [31:0] ctrl_next = (ctrl_reg & ~wmask) | (wb_dat_i & wmask);
   wire logic [31:0] mbcfg_next = (mbcfg_reg & ~wmask) | (wb_dat_i & wmask);
   wire logic [31:0] demand_next = (demand_reg & ~wmask) | (wb_dat_i & wmask);

   // ctrl: [1:0] op mode, [3:2] gateway type, [4] fw update, [5] lc source,
   // [6] release, [9:7] boiler address
   wire logic [1:0] opm = ctrl_reg[1:0];
   wire logic [1:0] gwt = ctrl_reg[3:2];
   wire logic fw_upd = ctrl_reg[4];
   // a zero divisor would stretch every bit to 65536 clocks, so it counts as one
   wire logic [15:0] mb_div = (mbcfg_reg[15:0] == 16'h0000) ? DIV_MIN : mbcfg_reg[15:0];
   wire logic mb_par_en = mbcfg_reg[16];
   wire logic mb_par_odd = mbcfg_reg[17];

   assign rd_data = hit_ctrl ? ctrl_reg :
                    hit_mbcfg ? mbcfg_reg :
                    hit_demand ? demand_reg :
                    hit_status ? {22'h0, record_busy_o, view_normal_o, reject_cnt_reg} :
                    hit_lcstat ? {lcstat_i.error, lcstat_i.manip, lcstat_i.ctrl_on,
                                  lcstat_i.actual} : 32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl_reg <= CTRL_RST;
         mbcfg_reg <= {16'h0000, MB_DIV_RST};
         demand_reg <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_reg <= req;
         wb_dat_o <= req ? rd_data : 32'h0000_0000;
         if (wr && hit_ctrl) begin
            ctrl_reg <= {22'h0, ctrl_next[9:0]};
         end
         if (wr && hit_mbcfg) begin
            mbcfg_reg <= {14'h0, mbcfg_next[17:0]};
         end
         if (wr && hit_demand) begin
            demand_reg <= {16'h0, demand_next[15:0]};
         end
      end
   end
   assign wb_ack_o = ack_reg;

   // ****************************************
   // operating mode and port routing
   // ****************************************
   typedef enum logic [2:0] {
      PM_PC = 3'b001,
      PM_GW_ON = 3'b010,
      PM_GW_OFF = 3'b100
   } tdg_pmode_t;
   tdg_pmode_t pmode;
   // reserved code 3 behaves as gateway off so that no port is ever left bridged twice
   assign pmode = (opm == OPM_PC) ? PM_PC : (opm == OPM_GW_ON) ? PM_GW_ON : PM_GW_OFF;
   wire logic ba_data_mode = (pmode == PM_GW_ON) && (gwt == GWT_DATA);
   wire logic ba_bridge = (pmode == PM_GW_ON) && (gwt != GWT_DATA);
   logic uart_line;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_txd_o <= 1'b1;
         ba_txd_o <= 1'b1;
         link_rxd_o <= 1'b1;
      end else if (ce_i) begin
         // only the selected port sees the link; the other idles high
         pc_txd_o <= (pmode == PM_PC) ? link_txd_i : 1'b1;
         // ebus and modbus answer what the link returns; data output sends the framer's records unasked
         ba_txd_o <= ba_bridge ? link_txd_i : ba_data_mode ? uart_line : 1'b1;
         unique case (pmode)
            PM_PC: link_rxd_o <= pc_rxd_i;
            PM_GW_ON: link_rxd_o <= ba_bridge ? ba_rxd_i : 1'b1;
            PM_GW_OFF: link_rxd_o <= 1'b1;
         endcase
      end
   end

   // ****************************************
   // pc port bit rate
   // ****************************************
   logic [15:0] pc_cnt_reg;
   wire logic [15:0] pc_div = fw_upd ? PC_DIV_FW_P : PC_DIV_STD_P;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_cnt_reg <= 16'h0000;
         pc_bit_tick_o <= 1'b0;
         pc_fw_rate_o <= 1'b0;
      end else if (ce_i) begin
         pc_fw_rate_o <= fw_upd;
         pc_bit_tick_o <= (pmode == PM_PC) && (pc_cnt_reg >= pc_div - 16'h0001);
         if ((pmode != PM_PC) || (pc_cnt_reg >= pc_div - 16'h0001)) begin
            pc_cnt_reg <= 16'h0000;
         end else begin
            pc_cnt_reg <= pc_cnt_reg + 16'h0001;
         end
      end
   end

   // ****************************************
   // automation write guard and load controller
   // ****************************************
   wire logic ba_wr_ok = ba_bridge && (gwt == GWT_MODBUS);
   wire logic ba_deny = ba_wr_i.safety | ba_wr_i.reset_cmd | ~ba_wr_ok;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ba_wr_grant_o <= 1'b0;
         ba_wr_reject_o <= 1'b0;
         reject_cnt_reg <= 8'h00;
         boiler_addr_o <= 3'h0;
         lc_release_o <= 1'b0;
         load_controller_source_select_o <= 1'b0;
         demand_o <= 16'h0000;
      end else if (ce_i) begin
         ba_wr_grant_o <= ba_wr_i.req & ~ba_deny;
         ba_wr_reject_o <= ba_wr_i.req & ba_deny;
         if (ba_wr_i.req && ba_deny && reject_cnt_reg != 8'hFF) begin
            reject_cnt_reg <= reject_cnt_reg + 8'h01;
         end
         boiler_addr_o <= ctrl_reg[9:7] & BOILER_MAX;
         load_controller_source_select_o <= ctrl_reg[5];
         lc_release_o <= ctrl_reg[6];
         demand_o <= demand_reg[15:0];
      end
   end

   // ****************************************
   // display view
   // ****************************************
   wire logic go_normal = key_info_i | (key_left_i & key_right_i);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         view_normal_o <= 1'b1;
      end else if (ce_i) begin
         // returning to the normal view wins over a menu entry in the same cycle
         if (go_normal) begin
            view_normal_o <= 1'b1;
         end else if (menu_enter_i) begin
            view_normal_o <= 1'b0;
         end
      end
   end

   // ****************************************
   // trending record assembly
   // ****************************************
   function automatic logic [7:0] fuel_code(input logic [2:0] sel);
      logic [7:0] c;
      c = FT_GAS_DIRECT;
      case (sel)
         3'h1: c = FT_GAS_PILOT1;
         3'h2: c = FT_GAS_PILOT2;
         3'h3: c = FT_LIGHT_OIL;
         3'h4: c = FT_HEAVY_OIL;
         3'h5: c = FT_LIGHT_OIL_GP;
         3'h6: c = FT_HEAVY_OIL_GP;
         default: c = FT_GAS_DIRECT;
      endcase
      return c;
   endfunction : fuel_code

   logic [4:0][15:0] pos_ofs;
   genvar gp;
   generate
      for (gp = 0; gp < 5; gp++) begin : g_pos
         // fields 3..7 are sent in the order air, fuel, aux1, aux2, aux3
         assign pos_ofs[4-gp] = trend_i.pos[gp] + POS_OFS;
      end
   endgenerate

   logic [REC_BYTES*8-1:0] rec_image, rec_reg;
   // first byte in the top bits; words high byte first
   assign rec_image = {trend_i.phase, fuel_code(trend_i.fuel_sel),
                       pos_ofs,
                       trend_i.vsd_speed + POS_OFS,
                       trend_i.o2_act, trend_i.load_act,
                       trend_i.temp_act, trend_i.temp_set,
                       trend_i.trim_var + TRIM_OFS,
                       trend_i.trim_stat, trend_i.o2_set,
                       trend_i.fgr_temp, trend_i.flame};

   // ****************************************
   // record framer and character sender
   // ****************************************
   typedef enum logic [2:0] {
      FR_IDLE = 3'b001,
      FR_LOAD = 3'b010,
      FR_SEND = 3'b100
   } tdg_fr_t;
   tdg_fr_t fr_reg;
   logic [4:0] byte_idx_reg;
   logic [10:0] sh_reg;
   logic [3:0] bit_cnt_reg;
   logic [15:0] baud_cnt_reg;
   wire logic [7:0] cur_byte = rec_reg[REC_BYTES*8-1 -: 8];
   wire logic par_bit = (^cur_byte) ^ mb_par_odd;
   wire logic [3:0] frame_bits = mb_par_en ? FRAME_BITS_P : FRAME_BITS_NP;
   wire logic bit_end = baud_cnt_reg >= mb_div - 16'h0001;
   wire logic char_end = bit_end && (bit_cnt_reg == frame_bits - 4'h1);
   assign uart_line = (fr_reg == FR_SEND) ? sh_reg[0] : 1'b1;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fr_reg <= FR_IDLE;
         rec_reg <= '0;
         byte_idx_reg <= 5'h00;
         sh_reg <= 11'h7FF;
         bit_cnt_reg <= 4'h0;
         baud_cnt_reg <= 16'h0000;
         record_busy_o <= 1'b0;
      end else if (ce_i) begin
         record_busy_o <= (fr_reg != FR_IDLE) && ba_data_mode;
         if (!ba_data_mode) begin
            fr_reg <= FR_IDLE;
         end else begin
            unique case (fr_reg)
               FR_IDLE: fr_reg <= FR_LOAD;
               FR_LOAD: begin
                  // snapshot so the record stays coherent while it is sent
                  rec_reg <= rec_image;
                  byte_idx_reg <= 5'h00;
                  sh_reg <= {1'b1, 1'b1, rec_image[REC_BYTES*8-1 -: 8], 1'b0};
                  bit_cnt_reg <= 4'h0;
                  baud_cnt_reg <= 16'h0000;
                  fr_reg <= FR_SEND;
               end
               FR_SEND: begin
                  baud_cnt_reg <= bit_end ? 16'h0000 : baud_cnt_reg + 16'h0001;
                  if (char_end && byte_idx_reg == REC_LAST) begin
                     // next record follows after one idle clock spent in FR_LOAD
                     fr_reg <= FR_LOAD;
                  end else if (char_end) begin
                     // characters of one record leave back to back
                     rec_reg <= {rec_reg[REC_BYTES*8-9:0], 8'h00};
                     byte_idx_reg <= byte_idx_reg + 5'h01;
                     sh_reg <= {1'b1, 1'b1, rec_reg[REC_BYTES*8-9 -: 8], 1'b0};
                     bit_cnt_reg <= 4'h0;
                  end else if (bit_end) begin
                     // parity slips in just ahead of the stop bit
                     sh_reg <= (bit_cnt_reg == 4'h8 && mb_par_en) ?
                               {2'b11, 8'hFF, par_bit} : {1'b1, sh_reg[10:1]};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            endcase
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   chk_ports_exclusive: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && pmode == PM_PC |=> ba_txd_o && !record_busy_o)
      else $error("both serial ports active");
   chk_link_pc_route: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && pmode == PM_PC |=> link_rxd_o == $past(pc_rxd_i))
      else $error("link not bridged to pc port");
   chk_gw_off_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && pmode == PM_GW_OFF |=> ba_txd_o && pc_txd_o && link_rxd_o)
      else $error("port active while gateway off");
   chk_safety_refused: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && ba_wr_i.req && (ba_wr_i.safety || ba_wr_i.reset_cmd)
      |=> ba_wr_reject_o && !ba_wr_grant_o)
      else $error("safety write accepted");
   chk_data_restart: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && ba_data_mode && fr_reg == FR_IDLE |=> fr_reg == FR_LOAD)
      else $error("data output not streaming");
   chk_record_head: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && fr_reg == FR_LOAD && ba_data_mode
      |=> rec_reg[REC_BYTES*8-9 -: 8] == fuel_code($past(trend_i.fuel_sel)))
      else $error("fuel code not second byte");
   chk_start_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && fr_reg == FR_LOAD && ba_data_mode ##1 ce_i && ba_data_mode |=> ba_txd_o == 1'b0)
      else $error("character does not start with a start bit");
   chk_view_return: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && key_left_i && key_right_i |=> view_normal_o)
      else $error("normal view not restored");
   chk_pc_rate: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && fw_upd |=> pc_fw_rate_o)
      else $error("firmware rate not selected");
   chk_wb_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o && ce_i |=> !wb_ack_o)
      else $error("ack held two cycles");

   cov_pc_mode: cover property (@(posedge clk_i) disable iff (rst_i) pmode == PM_PC);
   cov_record_done: cover property (@(posedge clk_i) disable iff (rst_i)
      char_end && byte_idx_reg == REC_LAST);
   cov_reject: cover property (@(posedge clk_i) disable iff (rst_i) ba_wr_reject_o);
   cov_grant: cover property (@(posedge clk_i) disable iff (rst_i) ba_wr_grant_o);
endmodule : tdg_gateway

// ### rtl/tdg_pkg.sv
// shared constants, encodings and carrier types of the trend data serial gateway
package tdg_pkg;
   // ****************************************
   // clock and bit rates
   // ****************************************
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned PC_BAUD_STD = 19_200;
   localparam int unsigned PC_BAUD_FW = 38_400;
   localparam int unsigned PC_DIV_STD = (CLK_HZ + PC_BAUD_STD / 2) / PC_BAUD_STD;
   localparam int unsigned PC_DIV_FW = (CLK_HZ + PC_BAUD_FW / 2) / PC_BAUD_FW;
   localparam logic [15:0] MB_DIV_RST = 16'h28B1;
   localparam logic [15:0] DIV_MIN = 16'h0001;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_MBCFG = 8'h04;
   localparam logic [7:0] ADR_DEMAND = 8'h08;
   localparam logic [7:0] ADR_STATUS = 8'h0C;
   localparam logic [7:0] ADR_LCSTAT = 8'h10;
   localparam logic [31:0] CTRL_RST = 32'h0000_0002;
   // ****************************************
   // field encodings
   // ****************************************
   localparam logic [1:0] OPM_PC = 2'h0;
   localparam logic [1:0] OPM_GW_ON = 2'h1;
   localparam logic [1:0] OPM_GW_OFF = 2'h2;
   localparam logic [1:0] GWT_EBUS = 2'h0;
   localparam logic [1:0] GWT_MODBUS = 2'h1;
   localparam logic [1:0] GWT_DATA = 2'h2;
   localparam logic [2:0] BOILER_MAX = 3'h7;
   // ****************************************
   // trending record
   // ****************************************
   localparam logic [7:0] FT_GAS_DIRECT = 8'h00;
   localparam logic [7:0] FT_GAS_PILOT1 = 8'h01;
   localparam logic [7:0] FT_GAS_PILOT2 = 8'h02;
   localparam logic [7:0] FT_LIGHT_OIL = 8'h13;
   localparam logic [7:0] FT_HEAVY_OIL = 8'h14;
   localparam logic [7:0] FT_LIGHT_OIL_GP = 8'h15;
   localparam logic [7:0] FT_HEAVY_OIL_GP = 8'h16;
   localparam logic [15:0] POS_OFS = 16'h0064;
   localparam logic [15:0] TRIM_OFS = 16'h01F4;
   localparam int unsigned REC_BYTES = 29;
   localparam logic [4:0] REC_LAST = 5'h1C;
   localparam logic [3:0] FRAME_BITS_NP = 4'hA;
   localparam logic [3:0] FRAME_BITS_P = 4'hB;

   typedef struct packed {
      logic [7:0] phase;
      logic [2:0] fuel_sel;
      logic [4:0][15:0] pos;
      logic [15:0] vsd_speed;
      logic [15:0] o2_act;
      logic [15:0] load_act;
      logic [15:0] temp_act;
      logic [15:0] temp_set;
      logic [15:0] trim_var;
      logic [7:0] trim_stat;
      logic [7:0] o2_set;
      logic [15:0] fgr_temp;
      logic [7:0] flame;
   } tdg_trend_t;

   typedef struct packed {
      logic req;
      logic safety;
      logic reset_cmd;
   } tdg_bawr_t;

   typedef struct packed {
      logic [15:0] actual;
      logic ctrl_on;
      logic [7:0] manip;
      logic [6:0] error;
   } tdg_lcstat_t;
endpackage : tdg_pkg

// ### testbench/tdg_serial_peer.sv
// serial peer at the automation port: decodes the characters the framer sends
`timescale 1ns/1ps
module tdg_serial_peer (
   // line side
   input wire logic clk_i,
   input wire logic line_i,
   input wire logic [15:0] div_i,
   // decoded characters
   output logic [7:0] byte_o,
   output logic [15:0] cnt_o,
   output logic [15:0] ferr_o
);
   logic [7:0] sh;
   // the peer only listens; it never starts an exchange on this port
   initial begin
      byte_o = 8'h00;
      cnt_o = 16'h0000;
      ferr_o = 16'h0000;
      sh = 8'h00;
      forever begin
         @(negedge clk_i);
         if (line_i === 1'b0) begin
            // sample mid-bit so a one-cycle skew of the sender does not matter
            repeat (div_i / 2) @(negedge clk_i);
            for (int i = 0; i < 8; i++) begin
               repeat (div_i) @(negedge clk_i);
               sh[i] = line_i;
            end
            repeat (div_i) @(negedge clk_i);
            if (line_i !== 1'b1) begin
               ferr_o = ferr_o + 16'h0001;
            end
            byte_o = sh;
            cnt_o = cnt_o + 16'h0001;
         end
      end
   end
endmodule : tdg_serial_peer

// ### testbench/trend_data_serial_gateway_tb.sv
// self-checking testbench of the trend data serial gateway
`timescale 1ns/1ps
module trend_data_serial_gateway_tb;
   import tdg_pkg::*;
   logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic pc_rxd_i, pc_txd_o, pc_bit_tick_o, pc_fw_rate_o, ba_rxd_i, ba_txd_o;
   logic ba_wr_grant_o, ba_wr_reject_o, link_txd_i, link_rxd_o, lc_release_o;
   logic load_controller_source_select_o, key_info_i, key_left_i, key_right_i;
   logic menu_enter_i, view_normal_o, record_busy_o;
   tdg_bawr_t ba_wr_i;
   tdg_trend_t trend_i;
   tdg_lcstat_t lcstat_i;
   logic [2:0] boiler_addr_o;
   logic [15:0] demand_o, cnt, last, ferr, pdiv;
   logic [7:0] rbyte, b;
   logic [7:0] ex[$];
   logic [7:0] ft[8] = '{FT_GAS_DIRECT, FT_GAS_PILOT1, FT_GAS_PILOT2, FT_LIGHT_OIL,
      FT_HEAVY_OIL, FT_LIGHT_OIL_GP, FT_HEAVY_OIL_GP, FT_GAS_DIRECT};
   int n_fail = 0;
   int cmp_count = 0;

   tdg_gateway #(.PC_DIV_STD_P(16'h0008), .PC_DIV_FW_P(16'h0004)) uut (
      .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .pc_rxd_i, .pc_txd_o, .pc_bit_tick_o,
      .pc_fw_rate_o, .ba_rxd_i, .ba_txd_o, .ba_wr_i, .ba_wr_grant_o, .ba_wr_reject_o,
      .link_txd_i, .link_rxd_o, .trend_i, .lcstat_i, .boiler_addr_o, .lc_release_o,
      .load_controller_source_select_o, .demand_o, .key_info_i, .key_left_i,
      .key_right_i, .menu_enter_i, .view_normal_o, .record_busy_o);
   tdg_serial_peer peer (.clk_i(clk_i), .line_i(ba_txd_o), .div_i(pdiv),
      .byte_o(rbyte), .cnt_o(cnt), .ferr_o(ferr));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      // ack and data are read as the rising edge samples them, then released
      do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 50) n_fail++;
   endtask : wb
   task automatic gap(input int exp_n);
      int n;
      // the first gap after a rate change may be short, so measure the third
      for (int k = 0; k < 3; k++) begin
         n = 0;
         do begin @(negedge clk_i); n++; end while (pc_bit_tick_o !== 1'b1 && n < 100);
      end
      check(32'(n), 32'(exp_n));
   endtask : gap
   task automatic guard(input logic s, input logic r, input logic ok);
      @(posedge clk_i);
      ba_wr_i <= '{1'b1, s, r};
      @(posedge clk_i);
      ba_wr_i <= '0;
      @(negedge clk_i);
      check(32'({ba_wr_grant_o, ba_wr_reject_o}), 32'({ok, ~ok}));
   endtask : guard
   task automatic key(input logic [3:0] k, input logic v);
      @(posedge clk_i);
      {key_info_i, key_left_i, key_right_i, menu_enter_i} <= k;
      @(posedge clk_i);
      {key_info_i, key_left_i, key_right_i, menu_enter_i} <= 4'h0;
      repeat (2) @(negedge clk_i);
      check(32'(view_normal_o), 32'(v));
   endtask : key
   task automatic get(output logic [7:0] v);
      int n;
      n = 0;
      while (cnt == last && n < 400) begin @(negedge clk_i); n++; end
      if (n >= 400) n_fail++;
      last = cnt;
      v = rbyte;
   endtask : get
   task automatic pw(input logic [15:0] w);
      ex.push_back(w[15:8]);
      ex.push_back(w[7:0]);
   endtask : pw
   task automatic enter_data(input logic [2:0] f);
      @(posedge clk_i);
      trend_i.fuel_sel <= f;
      wb(ADR_CTRL, 1'b1, 32'h2);
      // let a character cut off by the abort run out in the peer
      repeat (60) @(negedge clk_i);
      check(32'(ba_txd_o), 32'h1);
      last = cnt;
      wb(ADR_CTRL, 1'b1, 32'h9);
   endtask : enter_data

   // ****************************************
   // clock, watchdog and test sequence
   // ****************************************
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      repeat (40000) @(posedge clk_i);
      n_fail++;
      close_out();
   end
   initial begin
      {rst_i, ce_i, pc_rxd_i, ba_rxd_i, link_txd_i} = 5'h1F;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {43'h0, 4'hF};
      {key_info_i, key_left_i, key_right_i, menu_enter_i, ba_wr_i} = 7'h0;
      trend_i = '{8'h0C, 3'h3, {16'h00F4, 16'h00F3, 16'h00F2, 16'h00F1, 16'h00F0},
         16'h01F4, 16'h00C8, 16'h03E8, 16'h0078, 16'h0055, 16'h0020, 8'h5A, 8'h55,
         16'h0140, 8'h5F};
      lcstat_i = '{16'h1234, 1'b1, 8'hA5, 7'h33};
      pdiv = 16'h0004;
      ex.push_back(8'h0C);
      ex.push_back(FT_LIGHT_OIL);
      for (int i = 0; i < 5; i++) pw(trend_i.pos[i] + POS_OFS);
      pw(trend_i.vsd_speed + POS_OFS);
      pw(16'h00C8);
      pw(16'h03E8);
      pw(16'h0078);
      pw(16'h0055);
      pw(trend_i.trim_var + TRIM_OFS);
      ex.push_back(8'h5A);
      ex.push_back(8'h55);
      pw(16'h0140);
      ex.push_back(8'h5F);
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(ADR_CTRL, 1'b0, 32'h0);
      check(q, CTRL_RST);
      wb(8'h20, 1'b1, 32'hFFFF_FFFF);
      wb(8'h20, 1'b0, 32'h0);
      check(q, 32'h0);
      wb(ADR_CTRL, 1'b1, 32'h0);
      pc_rxd_i <= 1'b0;
      link_txd_i <= 1'b0;
      repeat (3) @(negedge clk_i);
      check(32'({pc_txd_o, ba_txd_o, link_rxd_o}), 32'h2);
      gap(8);
      wb(ADR_CTRL, 1'b1, 32'h10);
      gap(4);
      check(32'(pc_fw_rate_o), 32'h1);
      wb(ADR_CTRL, 1'b1, 32'h5);
      pc_rxd_i <= 1'b1;
      ba_rxd_i <= 1'b0;
      repeat (3) @(negedge clk_i);
      check(32'({pc_txd_o, ba_txd_o, link_rxd_o}), 32'h4);
      guard(1'b0, 1'b0, 1'b1);
      guard(1'b1, 1'b0, 1'b0);
      guard(1'b0, 1'b1, 1'b0);
      wb(ADR_CTRL, 1'b1, 32'h1);
      guard(1'b0, 1'b0, 1'b0);
      wb(ADR_CTRL, 1'b1, 32'h3E2);
      guard(1'b0, 1'b0, 1'b0);
      check(32'({pc_txd_o, ba_txd_o, link_rxd_o}), 32'h7);
      wb(ADR_DEMAND, 1'b1, 32'h0000_BEEF);
      wb(ADR_STATUS, 1'b0, 32'h0);
      check(q, 32'h104);
      check({boiler_addr_o, lc_release_o, load_controller_source_select_o, demand_o},
         21'h1FBEEF);
      wb(ADR_LCSTAT, 1'b0, 32'h0);
      check(q, 32'h674B_1234);
      // a frozen block must ignore the menu key
      ce_i <= 1'b0;
      key(4'h1, 1'b1);
      @(posedge clk_i);
      ce_i <= 1'b1;
      key(4'h1, 1'b0);
      key(4'h6, 1'b1);
      key(4'h1, 1'b0);
      key(4'h9, 1'b1);
      @(posedge clk_i);
      wb_sel_i <= 4'h3;
      wb(ADR_MBCFG, 1'b1, {16'hFFFF, pdiv});
      wb_sel_i <= 4'hF;
      wb(ADR_MBCFG, 1'b0, 32'h0);
      check(q, {16'h0000, pdiv});
      for (int f = 0; f < 8; f++) begin
         enter_data(3'(f));
         get(b);
         get(b);
         check(32'(b), 32'(ft[f]));
         check(32'(record_busy_o), 32'h1);
      end
      enter_data(3'h3);
      for (int i = 0; i < REC_BYTES; i++) begin
         get(b);
         check(32'(b), 32'(ex[i]));
      end
      check(32'(ferr), 32'h0);
      close_out();
   end
endmodule : trend_data_serial_gateway_tb
